//--- hw/tmr_consts.vh
/*
 * constants for the 16-bit byte-accessed timer: byte addresses, field
 * positions, fixed top values and reset values.
 * assumes it is included by bare name from the design files.
 */
//
// Overview of operation
// - 16-bit registers reached as two bytes
// - one shared high-byte holding register
// - low-byte write loads held high plus low
// - low-byte read copies high byte to holder
// - compare reads bypass the holding register
// - control b is plain 8-bit read/write; control a reads back bits 1:0 only
// - tick from prescaler or external pin edge
// - no clock selected means counter stays idle
// - counter counts up or down per direction
// - compare registers double buffered, compared continuously
// - compare match sets that unit's flag
// - capture edge copies counter into capture value unless capture is top
// - optional noise filter ahead of capture edge
// - bottom is 0x0000, max is 0xffff
// - top is fixed value, compare a, or capture
// - compare a as top gives no pwm output on compare a
// - four flags, each visible and individually masked
// - force bits in control a, mode bits 4:3 in b
// - processor counter write beats clear or count
// - capture flag set with the capture copy
// - clock select zero stops, counter still accessible
`ifndef TMR_CONSTS_VH
`define TMR_CONSTS_VH

// byte addresses on the 8-bit register port
`define TMR_A_CTRL_A    4'h0
`define TMR_A_CTRL_B    4'h1
`define TMR_A_CNT_L     4'h2
`define TMR_A_CNT_H     4'h3
`define TMR_A_CMPA_L    4'h4
`define TMR_A_CMPA_H    4'h5
`define TMR_A_CMPB_L    4'h6
`define TMR_A_CMPB_H    4'h7
`define TMR_A_CAP_L     4'h8
`define TMR_A_CAP_H     4'h9

// control a: force bits
`define TMR_FOC_A       3
`define TMR_FOC_B       2
// control b fields
`define TMR_NOISE_EN    7
`define TMR_CAP_EDGE    6
`define TMR_WGM3        4
`define TMR_WGM2        3

// flag/mask bit order
`define TMR_F_OVF       0
`define TMR_F_CMPB      1
`define TMR_F_CMPA      2
`define TMR_F_CAP       3

`define TMR_BOTTOM      16'h0000
`define TMR_MAX         16'hffff
`define TMR_TOP8        16'h00ff
`define TMR_TOP9        16'h01ff
`define TMR_TOP10       16'h03ff

// clock select encodings
`define TMR_CS_STOP     3'h0
`define TMR_CS_DIV1     3'h1
`define TMR_CS_DIV8     3'h2
`define TMR_CS_DIV64    3'h3
`define TMR_CS_DIV256   3'h4
`define TMR_CS_DIV1024  3'h5
`define TMR_CS_EXT_FALL 3'h6
`define TMR_CS_EXT_RISE 3'h7

`define TMR_NOISE_LEN   4
`define TMR_RST_BYTE    8'h00
`define TMR_RST_WORD    16'h0000

`endif

//--- hw/tmr_sync.v
/*
 * two-flop synchroniser for one asynchronous pin.
 * assumes the input is unrelated to clock_i.
 */
module tmr_sync (
	// clock and reset
	input  wire clock_i,
	input  wire rst_n_i,
	// pin
	input  wire pin_i,
	output reg  pin_o
);
	reg meta;

	always @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			meta  <= 1'b0;
			pin_o <= 1'b0;
		end else begin
			meta  <= pin_i;
			pin_o <= meta;
		end
	end
endmodule // tmr_sync

//--- hw/tmr_filter.v
/*
 * capture input noise filter: output follows only after LEN equal samples.
 * assumes the input is already synchronised to clock_i.
 */
module tmr_filter #(
	parameter LEN = 4
) (
	// clock and reset
	input  wire clock_i,
	input  wire rst_n_i,
	// signal
	input  wire enable_i,
	input  wire sig_i,
	output reg  sig_o
);
	reg [LEN-1:0] hist;

	always @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			hist  <= {LEN{1'b0}};
			sig_o <= 1'b0;
		end else begin
			hist <= {hist[LEN-2:0], sig_i};
			if (!enable_i)
				sig_o <= sig_i;
			else if (&hist)
				sig_o <= 1'b1;
			else if (~|hist)
				sig_o <= 1'b0;
		end
	end
endmodule // tmr_filter

//--- hw/tmr_core.v
/*
 * 16-bit timer/counter with two double-buffered compare units, one
 * input capture unit, a shared high-byte holding register and its own
 * prescaler. a processor core reaches it through an 8-bit byte port.
 * assumes read and write strobes are one-cycle pulses on clock_i,
 * and that flags are cleared by writing ones on the flag clear port.
 */
`include "tmr_consts.vh"

module tmr_core #(
	parameter NOISE_LEN = `TMR_NOISE_LEN
) (
	// clock and reset
	input  wire       clock_i,
	input  wire       rst_n_i,
	// byte register port
	input  wire [3:0] addr_i,
	input  wire [7:0] wdata_i,
	input  wire       wr_i,
	input  wire       rd_i,
	output reg  [7:0] rdata_o,
	// shared flag and mask bits
	input  wire [3:0] flag_clear_i,
	input  wire [3:0] shared_mask_reg_i,
	output wire [3:0] shared_flag_reg_o,
	output wire [3:0] irq_o,
	// prescaler and direction
	input  wire       prescaler_reset_i,
	input  wire       count_down_i,
	// pins
	input  wire       ext_count_pin_i,
	input  wire       capture_pin_i,
	input  wire       comparator_i,
	input  wire       capture_from_comparator_i,
	// compare results and timer tick toward the waveform generators
	output reg        compare_out_a_o,
	output reg        compare_out_b_o,
	output wire       timer_tick_o
);
	reg  [7:0]  timer_control_a;
	reg  [7:0]  timer_control_b;
	reg  [15:0] timer_count;
	reg  [15:0] compare_value_a;
	reg  [15:0] compare_value_b;
	reg  [15:0] cmp_buf_a;
	reg  [15:0] cmp_buf_b;
	reg  [15:0] capture_value;
	reg  [7:0]  hold_high;
	reg  [3:0]  flags;
	reg  [9:0]  prescale;
	reg  [9:0]  prescale_d;
	reg         ext_d;
	reg         cap_d;
	reg  [15:0] top;
	reg  [7:0]  next_rdata;
	reg         tick;

	wire [2:0]  clock_select_field = timer_control_b[2:0];
	wire [3:0]  wave_mode_field = {timer_control_b[`TMR_WGM3],
		timer_control_b[`TMR_WGM2], timer_control_a[1:0]};
	wire        ext_s;
	wire        cap_s;
	wire        cap_f;
	// the source is chosen ahead of the filter so both inputs are cleaned
	wire        cap_raw = capture_from_comparator_i ? comparator_i : cap_s;
	wire        cap_src = cap_f;
	wire        cap_edge_rise = timer_control_b[`TMR_CAP_EDGE];
	wire        wr_cnt_l = wr_i && (addr_i == `TMR_A_CNT_L);
	wire        wr_cmpa_l = wr_i && (addr_i == `TMR_A_CMPA_L);
	wire        wr_cmpb_l = wr_i && (addr_i == `TMR_A_CMPB_L);
	wire        wr_cap_l = wr_i && (addr_i == `TMR_A_CAP_L);
	wire        top_is_cmpa = (wave_mode_field == 4'h4) ||
		(wave_mode_field == 4'h9) || (wave_mode_field == 4'hb) ||
		(wave_mode_field == 4'hf);
	wire        top_is_cap = (wave_mode_field == 4'h8) ||
		(wave_mode_field == 4'ha) || (wave_mode_field == 4'hc) ||
		(wave_mode_field == 4'he);
	// pwm modes latch the compare buffers at the end of the period
	wire        pwm_mode = (wave_mode_field != 4'h0) &&
		(wave_mode_field != 4'h4) && (wave_mode_field != 4'hc);
	wire        cap_event;
	wire        at_top = (timer_count == top);
	wire        at_bottom = (timer_count == `TMR_BOTTOM);
	wire        cmp_match_a = (timer_count == compare_value_a);
	wire        cmp_match_b = (timer_count == compare_value_b);
	wire        ovf_event;

	// pins
	tmr_sync u_sync_ext (
		.clock_i (clock_i),
		.rst_n_i (rst_n_i),
		.pin_i   (ext_count_pin_i),
		.pin_o   (ext_s)
	);

	tmr_sync u_sync_cap (
		.clock_i (clock_i),
		.rst_n_i (rst_n_i),
		.pin_i   (capture_pin_i),
		.pin_o   (cap_s)
	);

	tmr_filter #(
		.LEN (NOISE_LEN)
	) u_filter (
		.clock_i  (clock_i),
		.rst_n_i  (rst_n_i),
		.enable_i (timer_control_b[`TMR_NOISE_EN]),
		.sig_i    (cap_raw),
		.sig_o    (cap_f)
	);

	// free running prescaler shared by all taps
	always @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			prescale   <= 10'h000;
			prescale_d <= 10'h000;
			ext_d      <= 1'b0;
			cap_d      <= 1'b0;
		end else begin
			prescale   <= prescaler_reset_i ? 10'h000 : prescale + 10'h001;
			prescale_d <= prescale;
			ext_d      <= ext_s;
			cap_d      <= cap_src;
		end
	end

	// one tick per selected tap wrap or pin edge
	always @* begin
		case (clock_select_field)
		`TMR_CS_STOP:     tick = 1'b0;
		`TMR_CS_DIV1:     tick = 1'b1;
		`TMR_CS_DIV8:     tick = prescale_d[2] & ~prescale[2];
		`TMR_CS_DIV64:    tick = prescale_d[5] & ~prescale[5];
		`TMR_CS_DIV256:   tick = prescale_d[7] & ~prescale[7];
		`TMR_CS_DIV1024:  tick = prescale_d[9] & ~prescale[9];
		`TMR_CS_EXT_FALL: tick = ext_d & ~ext_s;
		`TMR_CS_EXT_RISE: tick = ~ext_d & ext_s;
		default:          tick = 1'b0;
		endcase
	end
	assign timer_tick_o = tick;

	// top selection
	always @* begin
		case (wave_mode_field[1:0])
		2'h1:    top = `TMR_TOP8;
		2'h2:    top = `TMR_TOP9;
		2'h3:    top = `TMR_TOP10;
		default: top = `TMR_MAX;
		endcase
		if (top_is_cmpa)
			top = compare_value_a;
		else if (top_is_cap)
			top = capture_value;
	end

	assign cap_event = (cap_edge_rise ? (~cap_d & cap_src) :
		(cap_d & ~cap_src)) && !top_is_cap;
	assign ovf_event = tick && (count_down_i ? at_bottom : at_top);

	// counter; a processor write wins over count and clear
	always @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i)
			timer_count <= `TMR_RST_WORD;
		else if (wr_cnt_l)
			timer_count <= {hold_high, wdata_i};
		else if (tick) begin
			if (count_down_i)
				timer_count <= at_bottom ? top :
					timer_count - 16'h0001;
			else
				timer_count <= at_top ? `TMR_BOTTOM :
					timer_count + 16'h0001;
		end
	end

	// register writes and double buffering
	always @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			timer_control_a <= `TMR_RST_BYTE;
			timer_control_b <= `TMR_RST_BYTE;
			cmp_buf_a       <= `TMR_RST_WORD;
			cmp_buf_b       <= `TMR_RST_WORD;
			compare_value_a <= `TMR_RST_WORD;
			compare_value_b <= `TMR_RST_WORD;
			capture_value   <= `TMR_RST_WORD;
			hold_high       <= `TMR_RST_BYTE;
		end else begin
			if (wr_i && addr_i == `TMR_A_CTRL_A)
				timer_control_a <= wdata_i;
			if (wr_i && addr_i == `TMR_A_CTRL_B)
				timer_control_b <= wdata_i;
			if (wr_i && (addr_i == `TMR_A_CNT_H ||
				addr_i == `TMR_A_CMPA_H || addr_i == `TMR_A_CMPB_H ||
				addr_i == `TMR_A_CAP_H))
				hold_high <= wdata_i;
			else if (rd_i && addr_i == `TMR_A_CNT_L)
				hold_high <= timer_count[15:8];
			else if (rd_i && addr_i == `TMR_A_CAP_L)
				hold_high <= capture_value[15:8];
			if (wr_cmpa_l)
				cmp_buf_a <= {hold_high, wdata_i};
			if (wr_cmpb_l)
				cmp_buf_b <= {hold_high, wdata_i};
			// non-pwm modes update at once, pwm modes at top
			if (!pwm_mode || (tick && at_top)) begin
				compare_value_a <= wr_cmpa_l ? {hold_high, wdata_i} :
					cmp_buf_a;
				compare_value_b <= wr_cmpb_l ? {hold_high, wdata_i} :
					cmp_buf_b;
			end
			if (wr_cap_l)
				capture_value <= {hold_high, wdata_i};
			else if (cap_event)
				capture_value <= timer_count;
		end
	end

	// flags: hardware set wins over a same-cycle clear
	always @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i)
			flags <= 4'h0;
		else begin
			flags <= flags & ~flag_clear_i;
			if (ovf_event)
				flags[`TMR_F_OVF] <= 1'b1;
			if (tick && cmp_match_b)
				flags[`TMR_F_CMPB] <= 1'b1;
			if (tick && cmp_match_a)
				flags[`TMR_F_CMPA] <= 1'b1;
			if (cap_event)
				flags[`TMR_F_CAP] <= 1'b1;
		end
	end
	assign shared_flag_reg_o = flags;
	assign irq_o = flags & shared_mask_reg_i;

	// compare results; force bits strobe a match without a flag
	always @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			compare_out_a_o <= 1'b0;
			compare_out_b_o <= 1'b0;
		end else begin
			compare_out_a_o <= (cmp_match_a && !(pwm_mode && top_is_cmpa)) ||
				(wr_i && addr_i == `TMR_A_CTRL_A &&
				wdata_i[`TMR_FOC_A]);
			compare_out_b_o <= cmp_match_b || (wr_i &&
				addr_i == `TMR_A_CTRL_A && wdata_i[`TMR_FOC_B]);
		end
	end

	// read mux; compare reads come straight from the register
	always @* begin
		case (addr_i)
		`TMR_A_CTRL_A: next_rdata = {4'h0, timer_control_a[3:0] &
			4'h3}; // force bits always read as zero
		`TMR_A_CTRL_B: next_rdata = timer_control_b;
		`TMR_A_CNT_L:  next_rdata = timer_count[7:0];
		`TMR_A_CNT_H:  next_rdata = hold_high;
		`TMR_A_CMPA_L: next_rdata = compare_value_a[7:0];
		`TMR_A_CMPA_H: next_rdata = compare_value_a[15:8];
		`TMR_A_CMPB_L: next_rdata = compare_value_b[7:0];
		`TMR_A_CMPB_H: next_rdata = compare_value_b[15:8];
		`TMR_A_CAP_L:  next_rdata = capture_value[7:0];
		`TMR_A_CAP_H:  next_rdata = hold_high;
		default:       next_rdata = 8'h00;
		endcase
	end

	always @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i)
			rdata_o <= 8'h00;
		else if (rd_i)
			rdata_o <= next_rdata;
	end
endmodule // tmr_core

//--- testbench/tmr_core_checker.sv
/* concurrent checks on the timer byte port, flags, irq and tick.
   assumes it is bound to tmr_core; clock select is shadowed from writes. */
module tmr_core_checker #(
	parameter NOISE_LEN = 4
) (
	// clock and reset
	input wire       clock_i,
	input wire       rst_n_i,
	// byte port
	input wire [3:0] addr_i,
	input wire [7:0] wdata_i,
	input wire       wr_i,
	input wire       rd_i,
	input wire [7:0] rdata_o,
	// flags and pins
	input wire [3:0] flag_clear_i,
	input wire [3:0] shared_mask_reg_i,
	input wire [3:0] shared_flag_reg_o,
	input wire [3:0] irq_o,
	input wire       ext_count_pin_i,
	input wire       capture_pin_i,
	input wire       comparator_i,
	input wire       timer_tick_o
);
	timeunit 1ns;
	timeprecision 1ns;
	reg [2:0] cs;
	reg [7:0] ext_age;
	reg [7:0] cap_age;
	// ages saturate so long idle spans never wrap into a false match
	always @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			cs <= 3'h0;
			ext_age <= 8'hff;
			cap_age <= 8'hff;
		end else begin
			if (wr_i && addr_i == 4'h1)
				cs <= wdata_i[2:0];
			ext_age <= (ext_count_pin_i != $past(ext_count_pin_i)) ? 8'h00 :
				ext_age + (ext_age != 8'hff);
			cap_age <= (capture_pin_i != $past(capture_pin_i) ||
				comparator_i != $past(comparator_i)) ? 8'h00 :
				cap_age + (cap_age != 8'hff);
		end
	end
	default clocking @(posedge clock_i); endclocking
	default disable iff (!rst_n_i);
	irq_mask_a: assert property (
		irq_o == (shared_flag_reg_o & shared_mask_reg_i))
		else $error("irq not flags and mask");
	stop_idle_a: assert property (
		cs == 3'h0 |-> !timer_tick_o)
		else $error("tick while stopped");
	cmp_tick_a: assert property (
		$rose(shared_flag_reg_o[2]) || $rose(shared_flag_reg_o[1])
		|-> $past(timer_tick_o))
		else $error("compare flag without tick");
	ovf_tick_a: assert property (
		$rose(shared_flag_reg_o[0]) |-> $past(timer_tick_o))
		else $error("overflow flag without tick");
	flag_clear_a: assert property (
		($past(shared_flag_reg_o) & ~shared_flag_reg_o &
		~$past(flag_clear_i)) == 4'h0)
		else $error("flag fell without clear");
	cap_src_a: assert property (
		$rose(shared_flag_reg_o[3]) |-> cap_age <= NOISE_LEN + 6)
		else $error("capture with no source edge");
	ext_src_a: assert property (
		timer_tick_o && cs[2:1] == 2'b11 |-> ext_age <= 8'd5)
		else $error("external tick with no pin edge");
	ctrl_rw_a: assert property (
		wr_i && addr_i == 4'h1 ##2 rd_i && addr_i == 4'h1
		|=> rdata_o == $past(wdata_i, 3))
		else $error("control readback differs");
	low_wr_a: assert property (
		cs == 3'h0 && wr_i && addr_i == 4'h2 ##2 rd_i && addr_i == 4'h2
		|=> rdata_o == $past(wdata_i, 3))
		else $error("count low readback differs");
	cover property ($rose(shared_flag_reg_o[0]));
	cover property ($rose(shared_flag_reg_o[3]));
	cover property (timer_tick_o && cs == 3'h6);
endmodule // tmr_core_checker

//--- testbench/tmr_cpu_model.sv
/* processor core model driving the timer byte port.
   assumes a single caller, so each two-byte access stays atomic. */
module tmr_cpu_model (
	input  wire       clock_i,
	input  wire [7:0] rdata_i,
	output reg  [3:0] addr_o,
	output reg  [7:0] wdata_o,
	output reg        wr_o,
	output reg        rd_o
);
	timeunit 1ns;
	timeprecision 1ns;
	initial begin
		addr_o = 4'hf;
		wdata_o = 8'h00;
		wr_o = 1'b0;
		rd_o = 1'b0;
	end
	task wr8(input [3:0] a, input [7:0] d);
		@(posedge clock_i);
		addr_o <= a;
		wdata_o <= d;
		wr_o <= 1'b1;
		@(posedge clock_i);
		wr_o <= 1'b0;
		wdata_o <= ~d; // released bus must not echo stale data
	endtask
	task rd8(input [3:0] a, output [7:0] d);
		@(posedge clock_i);
		addr_o <= a;
		rd_o <= 1'b1;
		@(posedge clock_i);
		rd_o <= 1'b0;
		@(negedge clock_i);
		d = rdata_i;
	endtask
	task wr16(input [3:0] a, input [15:0] v);
		wr8(a + 4'h1, v[15:8]);
		wr8(a, v[7:0]);
	endtask
	task rd16(input [3:0] a, output [15:0] v);
		rd8(a, v[7:0]);
		rd8(a + 4'h1, v[15:8]);
	endtask
endmodule // tmr_cpu_model

//--- testbench/tmr_core_tb.sv
/* self-checking bench for tmr_core with a processor core model.
   assumes hw/ is on the include path; capture value is never written. */
module tmr_core_tb;
	timeunit 1ns;
	timeprecision 1ns;
	reg         clock, rst_n, down, ext, cap, cmp, cap_cmp;
	reg  [3:0]  flag_clear, mask;
	wire [3:0]  addr, flags, irq;
	wire [7:0]  wdata, rdata;
	wire        wr, rd, ca, cb;
	reg  [7:0]  b;
	reg  [15:0] v, w, u;
	integer     n_mismatch, total_checks, seed, i;
	tmr_cpu_model i_cpu (.clock_i(clock), .rdata_i(rdata), .addr_o(addr),
		.wdata_o(wdata), .wr_o(wr), .rd_o(rd));
	tmr_core #(.NOISE_LEN(4)) i_dut (.clock_i(clock), .rst_n_i(rst_n),
		.addr_i(addr), .wdata_i(wdata), .wr_i(wr), .rd_i(rd),
		.rdata_o(rdata), .flag_clear_i(flag_clear),
		.shared_mask_reg_i(mask), .shared_flag_reg_o(flags), .irq_o(irq),
		.prescaler_reset_i(1'b0), .count_down_i(down),
		.ext_count_pin_i(ext), .capture_pin_i(cap), .comparator_i(cmp),
		.capture_from_comparator_i(cap_cmp), .compare_out_a_o(ca),
		.compare_out_b_o(cb), .timer_tick_o());
	function [15:0] after_ticks(input [15:0] s, input integer n, input dn);
		after_ticks = dn ? s - n : s + n;
	endfunction
	task chk(input [15:0] seen, input [15:0] exp);
		total_checks = total_checks + 1;
		if (seen !== exp) begin
			n_mismatch = n_mismatch + 1;
			$display("wrong value at %0t: %h not %h", $time, seen, exp);
		end
	endtask
	task report_and_stop;
		$display("checks %0d mismatches %0d", total_checks, n_mismatch);
		if (n_mismatch == 0 && total_checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	task clr;
		flag_clear <= 4'hf;
		@(posedge clock);
		flag_clear <= 4'h0;
	endtask
	task run(input [7:0] ctl, input integer n);
		i_cpu.wr8(4'h1, ctl);
		repeat (n) @(posedge clock);
		i_cpu.wr8(4'h1, ctl & 8'hf8);
	endtask
	initial begin
		clock = 1'b0;
		forever #20 clock = ~clock;
	end
	initial begin
		#400000;
		n_mismatch = n_mismatch + 1;
		report_and_stop;
	end
	initial begin
		{rst_n, down, ext, cap, cmp, cap_cmp} = 6'h00;
		flag_clear = 4'h0;
		mask = 4'h0;
		seed = 32'hace0840c;
		n_mismatch = 0;
		total_checks = 0;
		repeat (4) @(posedge clock);
		rst_n <= 1'b1;
		i_cpu.rd16(4'h2, w);
		chk(w, 16'h0000);
		b = $random(seed) & 8'hd8;
		i_cpu.wr8(4'h1, b);
		i_cpu.rd8(4'h1, w[7:0]);
		chk(w[7:0], b);
		i_cpu.wr8(4'h1, 8'h00);
		for (i = 0; i < 4; i = i + 1) begin
			v = $random(seed);
			i_cpu.wr16(4'h2, v);
			i_cpu.rd16(4'h2, w);
			chk(w, v);
		end
		$display("byte access test done");
		w = ~v;
		i_cpu.wr16(4'h4, w);
		i_cpu.rd8(4'h2, b);
		i_cpu.rd8(4'h5, b);
		chk(b, w[15:8]);
		i_cpu.rd8(4'h3, b);
		chk(b, v[15:8]);
		i_cpu.wr8(4'h3, 8'h5a);
		i_cpu.wr8(4'h6, 8'h3c);
		i_cpu.rd16(4'h6, w);
		chk(w, 16'h5a3c);
		i_cpu.wr16(4'h4, v);
		i_cpu.wr8(4'h6, v[7:0]);
		repeat (2) @(negedge clock);
		chk(ca, 1'b1);
		chk(cb, 1'b1);
		$display("holding register test done");
		for (i = 0; i < 2; i = i + 1) begin
			down <= i[0];
			i_cpu.wr16(4'h2, i ? 16'h0003 : 16'hfffa);
			clr;
			run(8'h01, 20);
			chk(flags[0], 1'b1);
			mask <= 4'h1;
			@(negedge clock);
			chk(irq[0], 1'b1);
			mask <= 4'h0;
			i_cpu.rd16(4'h2, w);
			chk(i ? w > 16'hffe0 : w < 16'h0020, 1'b1);
		end
		down <= 1'b0;
		i_cpu.wr16(4'h4, 16'h0108);
		i_cpu.wr16(4'h6, 16'h010c);
		i_cpu.wr16(4'h2, 16'h0100);
		clr;
		run(8'h01, 20);
		chk(flags[2:1], 2'b11);
		i_cpu.wr8(4'h0, 8'h01);
		i_cpu.wr16(4'h2, 16'h00f0);
		clr;
		run(8'h09, 40);
		i_cpu.rd16(4'h2, w);
		chk({flags[0], w < 16'h0100}, 2'b11);
		i_cpu.wr8(4'h0, 8'h00);
		i_cpu.wr8(4'h1, 8'h00);
		$display("counting test done");
		for (i = 0; i < 2; i = i + 1) begin
			v = $random(seed);
			i_cpu.wr16(4'h2, v);
			i_cpu.wr8(4'h1, 8'h07 - i);
			repeat (5) begin
				ext <= 1'b1;
				repeat (3) @(posedge clock);
				ext <= 1'b0;
				repeat (3) @(posedge clock);
			end
			i_cpu.wr8(4'h1, 8'h00);
			i_cpu.rd16(4'h2, w);
			chk(w, after_ticks(v, 5, 1'b0));
		end
		for (i = 0; i < 4; i = i + 1) begin
			cap_cmp <= i[0];
			i_cpu.wr8(4'h1, i[1] ? 8'hc0 : 8'h40);
			v = $random(seed);
			if (!i[1])
				u = v;
			i_cpu.wr16(4'h2, v);
			clr;
			{cmp, cap} <= i[0] ? 2'b10 : 2'b01;
			repeat (i[1] ? 2 : 8) @(posedge clock);
			{cmp, cap} <= 2'b00;
			repeat (10) @(posedge clock);
			chk(flags[3], !i[1]);
		end
		i_cpu.rd16(4'h8, w);
		chk(w, u);
		cap_cmp <= 1'b0;
		clr;
		cap <= 1'b1;
		repeat (10) @(posedge clock);
		chk(flags[3], 1'b1);
		i_cpu.rd16(4'h8, w);
		chk(w, v);
		$display("tick and capture test done");
		report_and_stop;
	end
endmodule // tmr_core_tb

bind tmr_core tmr_core_checker #(.NOISE_LEN(NOISE_LEN)) i_chk (.*);
